// ===== hdl/serial_memory_access_with_write_lock.sv
// Behaviour
// - Write: select with direction 0, ack it, ack two address bytes, then data.
// - Locked without password: memory unchanged, data bytes not acknowledged.
// - Sixteen bit byte address, high byte sent first, low byte second.
// - Write cycle starts only on a stop right after a data acknowledge.
// - After the write cycle the counter points past the last byte written.
// - While writing, data line released and all bus traffic ignored.
// - Byte write: locked without password gives no-ack, unchanged; else ack, master stops.
// - Page write holds one to four bytes in one row.
// - Page bytes acked when unlocked or password given; else no-ack.
// - Page write address steps within the row after each page byte.
// - Select not acknowledged while write busy; acknowledged afterwards.
// - Reads work whatever the lock bit.
// - Counter increments by one after each byte read.
// - Random read: dummy write of address, repeated start, read select.
// - Current read: ack read select, send byte at counter, increment.
// - Sequential read: master acks each byte, ends with no-ack and stop.
// - Counter wraps from last address to zero during reads.
// - No acknowledge after a read byte ends the transfer into standby.
// - Memory holds all ones after reset.
// - Select answered only if chip-enable field matches pins; else standby.
// - Data line sampled on clock rise; changes only while clock low.
`timescale 1ns/1ns
`default_nettype none
module serial_memory_access_with_write_lock
	import tag_pkg::*;
#(
	parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES,
	parameter int MEM_SIZE = MEM_WORDS
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic CHIP_ENABLE_BIT0,
	input wire logic CHIP_ENABLE_BIT1,
	input wire logic WRITE_LOCK,
	input wire logic PASSWORD_OK,
	output logic BUSY,
	output logic [ADDR_W-1:0] ADDR_COUNTER
);
	localparam int MW = $clog2(MEM_SIZE);
	initial begin
		if (WRITE_CYCLE_COUNT < 1) $error("WRITE_CYCLE_COUNT must be positive");
		if ((1 << MW) != MEM_SIZE || MW > ADDR_W || MW < ROW_LSB_W)
			$error("MEM_SIZE must be a power of two within the address space");
	end

	// ------------------------------------------------------------------
	// Pin conditioning and bus events
	// ------------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	pin_sync u_scl (.MCLK(MCLK), .ARST_N(ARST_N), .d(SCL), .q(scl_s));
	pin_sync u_sda (.MCLK(MCLK), .ARST_N(ARST_N), .d(SDA_IN), .q(sda_s));
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_ev = scl_s && scl_d && sda_d && !sda_s;
	assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

	// ------------------------------------------------------------------
	// Protocol state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SELECT = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b110
	} phase_t;
	phase_t phase;
	logic [3:0] bit_cnt;
	logic [7:0] shifter;
	logic ack_drive;
	logic stop_armed;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] page_base;
	logic [ROW_LSB_W:0] page_cnt;
	logic [$clog2(WRITE_CYCLE_COUNT+1)-1:0] wc_cnt;
	logic [7:0] mem [MEM_SIZE];
	logic write_ok;
	logic byte_done;
	logic in_ack_slot;
	logic [7:0] rd_byte;
	assign write_ok = !WRITE_LOCK || PASSWORD_OK;
	assign in_ack_slot = bit_cnt == ACK_SLOT;
	assign byte_done = scl_rise && bit_cnt == 4'h7;
	assign BUSY = wc_cnt != '0;

	function automatic logic [ADDR_W-1:0] wrap_next(input logic [ADDR_W-1:0] a);
		wrap_next = (a + 1'b1) & ADDR_W'(MEM_SIZE - 1);
	endfunction

	// Pending page bytes wait here until the stop commits them
	logic pf_in_valid;
	logic pf_in_ready;
	logic pf_out_valid;
	logic pf_out_ready;
	logic [ADDR_W+7:0] pf_out;
	logic committing;
	logic pf_flush;
	assign pf_in_valid = phase == ST_WDATA && byte_done && write_ok && !committing;
	assign pf_out_ready = committing || pf_flush;
	byte_fifo #(.WIDTH(ADDR_W + 8), .DEPTH(FIFO_DEPTH)) u_page (
		.MCLK(MCLK),
		.ARST_N(ARST_N),
		.in_valid(pf_in_valid),
		.in_ready(pf_in_ready),
		.in_data({page_base, shifter[6:0], sda_s}),
		.out_valid(pf_out_valid),
		.out_ready(pf_out_ready),
		.out_data(pf_out)
	);

	// ------------------------------------------------------------------
	// Bit engine
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			phase <= ST_IDLE;
			bit_cnt <= '0;
			shifter <= '0;
			ack_drive <= 1'b0;
			stop_armed <= 1'b0;
			page_cnt <= '0;
			pf_flush <= 1'b0;
		end else if (BUSY || committing) begin
			phase <= ST_IDLE;
			ack_drive <= 1'b0;
			stop_armed <= 1'b0;
			pf_flush <= 1'b0;
		end else if (start_ev) begin
			phase <= ST_SELECT;
			// The clock fall that closes the start must land on slot zero
			bit_cnt <= ACK_SLOT;
			ack_drive <= 1'b0;
			stop_armed <= 1'b0;
			pf_flush <= pf_out_valid;
		end else if (stop_ev) begin
			phase <= ST_IDLE;
			ack_drive <= 1'b0;
			stop_armed <= 1'b0;
			pf_flush <= !stop_armed && pf_out_valid;
		end else begin
			pf_flush <= pf_flush && pf_out_valid;
			if (scl_rise && bit_cnt < ACK_SLOT) begin
				shifter <= {shifter[6:0], sda_s};
			end
			if (scl_fall) begin
				bit_cnt <= in_ack_slot ? 4'h0 : bit_cnt + 1'b1;
				stop_armed <= 1'b0;
				if (in_ack_slot) begin
					ack_drive <= 1'b0;
					stop_armed <= ack_drive && phase == ST_WDATA;
				end
			end
			if (byte_done) begin
				ack_drive <= 1'b1;
				case (phase)
					ST_SELECT: begin
						if (shifter[6:3] != DEV_TYPE
							|| shifter[1:0] != {CHIP_ENABLE_BIT1, CHIP_ENABLE_BIT0}) begin
							ack_drive <= 1'b0;
							phase <= ST_IDLE;
						end else if (sda_s) begin
							phase <= ST_RDATA;
						end else begin
							phase <= ST_ADDR_HI;
						end
					end
					ST_ADDR_HI: phase <= ST_ADDR_LO;
					ST_ADDR_LO: begin
						phase <= ST_WDATA;
						page_cnt <= '0;
					end
					ST_WDATA: begin
						ack_drive <= write_ok && pf_in_ready;
						page_cnt <= page_cnt + 1'b1;
					end
					ST_RDATA: begin
						ack_drive <= 1'b0;
						phase <= ST_RACK;
					end
					default: begin
						ack_drive <= 1'b0;
						phase <= ST_IDLE;
					end
				endcase
			end
			if (scl_rise && in_ack_slot && phase == ST_RACK) begin
				phase <= sda_s ? ST_IDLE : ST_RDATA;
			end
		end
	end

	// ------------------------------------------------------------------
	// Address counter
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] last_written;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			addr <= '0;
			page_base <= '0;
		end else if (committing && !pf_out_valid) begin
			addr <= wrap_next(last_written);
		end else if (!BUSY && !committing && !start_ev && !stop_ev) begin
			if (byte_done && phase == ST_ADDR_HI) begin
				addr[15:8] <= {shifter[6:0], sda_s};
			end
			if (byte_done && phase == ST_ADDR_LO) begin
				addr[7:0] <= {shifter[6:0], sda_s};
				page_base <= {addr[15:8], shifter[6:0], sda_s};
			end
			if (byte_done && phase == ST_WDATA) begin
				page_base[ROW_LSB_W-1:0] <= page_base[ROW_LSB_W-1:0] + 1'b1;
			end
			if (byte_done && phase == ST_RDATA) begin
				addr <= wrap_next(addr);
			end
		end
	end
	assign ADDR_COUNTER = addr;

	// ------------------------------------------------------------------
	// Write cycle and memory array
	// ------------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			committing <= 1'b0;
			wc_cnt <= '0;
		end else if (committing) begin
			if (!pf_out_valid) begin
				committing <= 1'b0;
				wc_cnt <= ($bits(wc_cnt))'(WRITE_CYCLE_COUNT);
			end
		end else if (BUSY) begin
			wc_cnt <= wc_cnt - 1'b1;
		end else if (stop_ev && stop_armed && pf_out_valid) begin
			committing <= 1'b1;
		end
	end
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			last_written <= '0;
		end else if (committing && pf_out_valid) begin
			last_written <= pf_out[ADDR_W+7:8];
		end
	end
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < MEM_SIZE; i++) begin
				mem[i] <= ERASED;
			end
		end else if (committing && pf_out_valid) begin
			mem[pf_out[8+MW-1:8]] <= pf_out[7:0];
		end
	end
	assign rd_byte = mem[addr[MW-1:0]];

	// ------------------------------------------------------------------
	// Data line driver
	// ------------------------------------------------------------------
	logic [7:0] tx;
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx <= '0;
			SDA_OE <= 1'b0;
		end else if (BUSY || committing || start_ev || stop_ev) begin
			SDA_OE <= 1'b0;
		end else if (scl_fall) begin
			if (bit_cnt == 4'h7) begin
				SDA_OE <= ack_drive;
			end else if (phase == ST_RDATA && (in_ack_slot || bit_cnt < 4'h7)) begin
				tx <= in_ack_slot ? {rd_byte[6:0], 1'b0} : {tx[6:0], 1'b0};
				SDA_OE <= in_ack_slot ? !rd_byte[7] : !tx[7];
			end else begin
				SDA_OE <= 1'b0;
			end
		end
	end
	assign SDA_OUT = 1'b0;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_busy_len: assert property (@(posedge MCLK) disable iff (!ARST_N)
		$rose(BUSY) |-> BUSY [*8])
		else $error("busy dropped early");
	chk_busy_quiet: assert property (@(posedge MCLK) disable iff (!ARST_N)
		BUSY |=> !SDA_OE)
		else $error("data line driven while busy");
	chk_lock_nack: assert property (@(posedge MCLK) disable iff (!ARST_N)
		phase == ST_WDATA && byte_done && !write_ok && !BUSY && !start_ev && !stop_ev
		|=> !ack_drive)
		else $error("locked data acknowledged");
	chk_lock_nowrite: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!write_ok |=> $stable(u_page.wp))
		else $error("locked byte queued");
	chk_commit_armed: assert property (@(posedge MCLK) disable iff (!ARST_N)
		$rose(committing) |-> $past(stop_armed))
		else $error("write started without armed stop");
	chk_read_incr: assert property (@(posedge MCLK) disable iff (!ARST_N)
		phase == ST_RDATA && byte_done && !BUSY && !committing && !start_ev && !stop_ev
		|=> addr == wrap_next($past(addr)))
		else $error("read counter did not step");
	chk_nack_standby: assert property (@(posedge MCLK) disable iff (!ARST_N)
		phase == ST_RACK && scl_rise && in_ack_slot && sda_s && !BUSY && !committing
		&& !start_ev && !stop_ev |=> phase == ST_IDLE)
		else $error("no-ack did not end read");
	chk_commit_bound: assert property (@(posedge MCLK) disable iff (!ARST_N)
		$rose(committing) |-> ##[1:5] !committing)
		else $error("commit too long");
	cov_write: cover property (@(posedge MCLK) disable iff (!ARST_N) $fell(committing));
	cov_read: cover property (@(posedge MCLK) disable iff (!ARST_N) phase == ST_RACK);
	cov_nack: cover property (@(posedge MCLK) disable iff (!ARST_N)
		byte_done && phase == ST_WDATA && !write_ok);
	cov_full_page: cover property (@(posedge MCLK) disable iff (!ARST_N)
		phase == ST_WDATA && page_cnt == (ROW_LSB_W+1)'(ROW_BYTES));
endmodule
`default_nettype wire

// ===== hdl/tag_pkg.sv
package tag_pkg;
	// Device type code; value is arbitrary
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam int ADDR_W = 16;
	localparam int MEM_WORDS = 256;
	localparam int ROW_BYTES = 4;
	localparam int ROW_LSB_W = 2;
	localparam logic [7:0] ERASED = 8'hff;
	localparam int CLK_MHZ = 100;
	localparam int WRITE_CYCLE_TIME_US = 5;
	localparam int WRITE_CYCLES = WRITE_CYCLE_TIME_US * CLK_MHZ;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam int FIFO_DEPTH = 4;
endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;
	// Three stages; level moves only when stages two and three agree
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			q <= 1'b1;
		end else if (s2 == s3) begin
			q <= s3;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/byte_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
) (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wp;
	logic [PW:0] rp;
	assign in_ready = (wp - rp) != (PW+1)'(DEPTH);
	assign out_valid = wp != rp;
	assign out_data = mem[rp[PW-1:0]];
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wp <= '0;
		end else if (in_valid && in_ready) begin
			wp <= wp + 1'b1;
		end
	end
	always_ff @(posedge MCLK) begin
		if (in_valid && in_ready) begin
			mem[wp[PW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rp <= '0;
		end else if (out_valid && out_ready) begin
			rp <= rp + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== verification/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model #(
	parameter int HALF = 16
) (
	input wire logic mclk,
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	// ----------------------------------------
	// Bus idles with clock high, data released
	// ----------------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic wait_half();
		repeat (HALF) @(negedge mclk);
	endtask

	// Also serves as repeated start
	task automatic start();
		repeat (2) @(negedge mclk);
		sda_low = 1'b0;
		wait_half();
		scl = 1'b1;
		wait_half();
		sda_low = 1'b1;
		wait_half();
		scl = 1'b0;
	endtask

	task automatic stop();
		repeat (2) @(negedge mclk);
		sda_low = 1'b1;
		wait_half();
		scl = 1'b1;
		wait_half();
		sda_low = 1'b0;
		wait_half();
	endtask

	// Data moves only while the clock is low
	task automatic bit_out(input logic b);
		repeat (2) @(negedge mclk);
		sda_low = !b;
		wait_half();
		scl = 1'b1;
		wait_half();
		scl = 1'b0;
	endtask

	task automatic bit_in(output logic b);
		repeat (2) @(negedge mclk);
		sda_low = 1'b0;
		wait_half();
		scl = 1'b1;
		repeat (HALF / 2) @(negedge mclk);
		b = sda_line;
		repeat (HALF / 2) @(negedge mclk);
		scl = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] d, output logic ack);
		int i;
		logic b;
		for (i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(b);
		ack = (b === 1'b0);
	endtask

	// Ack all but the last byte of a stream
	task automatic recv_byte(output logic [7:0] d, input logic ack);
		int i;
		for (i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(!ack);
	endtask
endmodule
`default_nettype wire

// ===== verification/serial_memory_access_with_write_lock_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_memory_access_with_write_lock_tb;
	import tag_pkg::*;
	localparam int WCC = 400;
	logic mclk, arst_n, ce0, ce1, lock, pw_ok, scl, m_low, sda_oe, busy, sda_out, hit;
	logic [ADDR_W-1:0] addr_cnt;
	logic [15:0] rnd;
	wire logic sda_line;
	int mem[MEM_WORDS];
	int ptr, n_fail, cmp_count, busy_len, k, n;
	logic [15:0] base;

	assign sda_line = !m_low && !(sda_oe && !sda_out);

	serial_memory_access_with_write_lock #(.WRITE_CYCLE_COUNT(WCC)) u_serial_memory_access_with_write_lock (
		.MCLK(mclk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda_line),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.CHIP_ENABLE_BIT0(ce0), .CHIP_ENABLE_BIT1(ce1), .WRITE_LOCK(lock), .PASSWORD_OK(pw_ok),
		.BUSY(busy), .ADDR_COUNTER(addr_cnt)
	);
	i2c_master_model #(.HALF(16)) u_i2c_master_model (
		.mclk(mclk), .scl(scl), .sda_low(m_low), .sda_line(sda_line)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Same upper seven bits in every select of a sequence
	function automatic logic [7:0] sel(input logic rw);
		return {DEV_TYPE, 1'b0, ce1, ce0, rw};
	endfunction

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic head(input logic [15:0] addr);
		logic a, b, c;
		u_i2c_master_model.start();
		u_i2c_master_model.send_byte(sel(1'b0), a);
		u_i2c_master_model.send_byte(addr[15:8], b);
		u_i2c_master_model.send_byte(addr[7:0], c);
		chk(16'({a, b, c}), 16'h0007, "select and address ack");
	endtask

	task automatic poll(input logic expect_busy);
		logic a;
		int j;
		a = 1'b0;
		for (j = 0; j < 20 && a !== 1'b1; j++) begin
			u_i2c_master_model.start();
			u_i2c_master_model.send_byte(sel(1'b0), a);
			u_i2c_master_model.stop();
			if (j == 0 && expect_busy) chk(16'(a), 16'h0000, "poll while busy");
		end
		chk(16'(a), 16'h0001, "poll ready");
	endtask

	// Start is row aligned and n stays within the row
	task automatic wr(input logic [15:0] addr, input int cnt, input logic exp_ack);
		logic a;
		logic [7:0] d;
		int i;
		head(addr);
		for (i = 0; i < cnt; i++) begin
			rnd = lfsr(rnd);
			d = rnd[7:0];
			u_i2c_master_model.send_byte(d, a);
			chk(16'(a), 16'(exp_ack), "data ack");
			if (exp_ack) mem[(addr + i) % MEM_WORDS] = d;
		end
		u_i2c_master_model.stop();
		if (exp_ack) begin
			ptr = (addr + cnt) % MEM_WORDS;
			for (i = 0; i < 40 && busy !== 1'b1; i++) @(negedge mclk);
			chk(16'(busy), 16'h0001, "busy after stop");
		end
		poll(exp_ack);
		if (exp_ack) chk(addr_cnt, 16'(ptr), "counter after write");
	endtask

	task automatic rd(input logic random, input logic [15:0] addr, input int cnt);
		logic a;
		logic [7:0] d;
		int i;
		if (random) begin
			head(addr);
			ptr = addr % MEM_WORDS;
		end
		u_i2c_master_model.start();
		u_i2c_master_model.send_byte(sel(1'b1), a);
		chk(16'(a), 16'h0001, "read select ack");
		for (i = 0; i < cnt; i++) begin
			u_i2c_master_model.recv_byte(d, i < cnt - 1);
			chk(16'(d), 16'(mem[ptr]), "read data");
			ptr = (ptr + 1) % MEM_WORDS;
		end
		u_i2c_master_model.stop();
		repeat (8) @(negedge mclk);
		chk(addr_cnt, 16'(ptr), "counter after read");
	endtask

	// ----------------------------------------
	// Clock, watchdog, busy length monitor
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		repeat (95000) @(posedge mclk);
		n_fail++;
		$display("Error at %0t: run did not finish", $time);
		print_verdict();
	end

	always @(negedge mclk) begin
		if (busy === 1'b1) begin
			busy_len++;
		end else if (busy_len != 0) begin
			chk(16'(busy_len), 16'(WCC), "busy length");
			busy_len = 0;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		rnd = 16'h4108;
		ce0 = rnd[3];
		ce1 = rnd[8];
		lock = 1'b0;
		pw_ok = 1'b0;
		busy_len = 0;
		for (k = 0; k < MEM_WORDS; k++) mem[k] = 255;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		repeat (8) @(negedge mclk);
		chk(addr_cnt, 16'h0000, "counter at reset");
		chk(16'(busy), 16'h0000, "busy at reset");
		rnd = lfsr(rnd);
		rd(1'b1, {8'h00, rnd[7:0]}, 2);
		for (n = 1; n <= ROW_BYTES; n++) begin
			rnd = lfsr(rnd);
			base = {8'h00, rnd[7:2], 2'b00};
			wr(base, n, 1'b1);
			rd(1'b1, base, n);
		end
		for (k = 0; k < 3; k++) begin
			lock = (k != 0);
			pw_ok = (k == 2);
			rnd = lfsr(rnd);
			base = {8'h00, rnd[7:2], 2'b00};
			wr(base, 1, !(lock && !pw_ok));
			rd(1'b1, base, 1);
		end
		rd(1'b1, 16'(MEM_WORDS - 1), 2);
		rd(1'b0, 16'h0000, 1);
		for (k = 0; k < 2; k++) begin
			u_i2c_master_model.start();
			u_i2c_master_model.send_byte(k == 0 ? {DEV_TYPE, 1'b0, !ce1, ce0, 1'b0} :
				{DEV_TYPE ^ 4'h3, 1'b0, ce1, ce0, 1'b0}, hit);
			chk(16'(hit), 16'h0000, "foreign select");
			u_i2c_master_model.stop();
		end
		lock = 1'b0;
		// The dummy write loads the counter even though no write follows
		base = 16'h0010;
		head(base);
		ptr = int'(base) % MEM_WORDS;
		u_i2c_master_model.stop();
		repeat (40) @(negedge mclk);
		chk(16'(busy), 16'h0000, "stop after address");
		rd(1'b0, 16'h0000, 1);
		print_verdict();
	end
endmodule
`default_nettype wire
